// ### hdl/rbls_params.svh
// constants for the ram self-check and loopback status block
`ifndef RBLS_PARAMS_SVH
`define RBLS_PARAMS_SVH
// register addresses (word addresses on the host register port)
`define RBLS_ADDR_CLUE 8'h1B
`define RBLS_ADDR_CTRL 8'h28
// control register field positions
`define RBLS_B_ENABLE 15
`define RBLS_B_PSEL_HI 13
`define RBLS_B_PSEL_LO 11
`define RBLS_B_RGO 10
`define RBLS_B_RPASS 9
`define RBLS_B_RFAIL 8
`define RBLS_B_ANALOG 5
`define RBLS_B_SYNC 4
`define RBLS_B_BUS 3
`define RBLS_B_LGO 2
`define RBLS_B_LPASS 1
`define RBLS_B_LFAIL 0
// quadrant geometry and reset values
`define RBLS_QUAD_SPAN 16'h2000
`define RBLS_CTRL_RST 16'h0000
`endif

// ### hdl/rbls_pkg.sv
// types for the ram self-check and loopback status block
package rbls_pkg;
	typedef enum logic [1:0] {
		RBLS_IDLE = 2'b00,
		RBLS_RUN = 2'b01,
		RBLS_DONE = 2'b10
	} rbls_state_t;
	// loopback configuration handed to the loopback engine
	typedef struct packed {
		logic analog;
		logic cmd_sync;
		logic bus_b;
		logic go;
	} rbls_loop_cfg_t;
	// ram checker per-quadrant compare report
	typedef struct packed {
		logic step;
		logic [3:0] mismatch;
		logic last;
	} rbls_ram_rep_t;
endpackage

// ### hdl/rbls_sync2.sv
// two-flop synchroniser for one level
`timescale 1ns/1ps
module rbls_sync2 (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// level in and out
	input wire logic d,
	output logic q
);
	logic meta_ff;
	logic q_ff;
	logic nxt_meta;
	logic nxt_q;
	// first stage is read only by the second stage
	always_comb begin
		nxt_meta = d;
		nxt_q = meta_ff;
	end
	always_ff @(posedge clk) begin
		if (!nrst) begin
			meta_ff <= 1'b0;
			q_ff <= 1'b0;
		end else begin
			meta_ff <= nxt_meta;
			q_ff <= nxt_q;
		end
	end
	assign q = q_ff;
endmodule

// ### hdl/rbls_top.sv
// self-check control register, ram check result and loopback selects
`timescale 1ns/1ps
`include "rbls_params.svh"
module rbls_top #(
	parameter int ADDR_W = 8,
	parameter int OFS_W = 13
) (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// factory check pin, asynchronous
	input wire logic test_pin,
	// host register port
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	output logic [15:0] reg_rdata,
	// rt1 message information word, shown at clue address in normal mode
	input wire logic [15:0] rt1_msg_info,
	// ram checker engine
	output logic ram_go,
	output logic [2:0] ram_check_pattern_select,
	output logic [OFS_W-1:0] ram_offset,
	input wire rbls_pkg::rbls_ram_rep_t ram_rep,
	// loopback engine
	output rbls_pkg::rbls_loop_cfg_t loop_cfg,
	output logic loop_tx_enable,
	input wire logic loop_done,
	input wire logic loop_ok
);
	logic test_s;
	logic [15:0] ctrl_ff;
	logic [15:0] nxt_ctrl;
	logic [OFS_W-1:0] ofs_ff;
	logic [OFS_W-1:0] nxt_ofs;
	logic [15:0] clue_ff;
	logic [15:0] nxt_clue;
	logic [15:0] rdata_ff;
	logic [15:0] nxt_rdata;
	rbls_pkg::rbls_state_t st_ff;
	rbls_pkg::rbls_state_t nxt_st;
	logic wr_ctrl;
	logic ram_start;
	logic loop_start;
	logic any_err;

	// ---------------------------------------------
	// pin synchronisation
	// ---------------------------------------------
	rbls_sync2 u_test_sync (
		.clk(clk),
		.nrst(nrst),
		.d(test_pin),
		.q(test_s)
	);

	// ---------------------------------------------
	// control register
	// ---------------------------------------------
	// ram start only when pin high and enable bit already set; loop start needs only the pin high
	assign wr_ctrl = reg_wr && (reg_addr == ADDR_W'(`RBLS_ADDR_CTRL));
	assign ram_start = wr_ctrl && reg_wdata[`RBLS_B_RGO] && test_s
		&& ctrl_ff[`RBLS_B_ENABLE] && !ctrl_ff[`RBLS_B_RGO];
	assign loop_start = wr_ctrl && reg_wdata[`RBLS_B_LGO] && test_s
		&& !ctrl_ff[`RBLS_B_LGO];
	// any quadrant mismatch counts; which quadrant failed is not kept
	assign any_err = |ram_rep.mismatch;

	// writable fields, self-clearing go bits, hardware-set flags
	always_comb begin
		nxt_ctrl = ctrl_ff;
		if (wr_ctrl) begin
			nxt_ctrl[`RBLS_B_ENABLE] = reg_wdata[`RBLS_B_ENABLE];
			nxt_ctrl[`RBLS_B_PSEL_HI:`RBLS_B_PSEL_LO] =
				reg_wdata[`RBLS_B_PSEL_HI:`RBLS_B_PSEL_LO];
			nxt_ctrl[`RBLS_B_ANALOG] = reg_wdata[`RBLS_B_ANALOG];
			nxt_ctrl[`RBLS_B_SYNC] = reg_wdata[`RBLS_B_SYNC];
			nxt_ctrl[`RBLS_B_BUS] = reg_wdata[`RBLS_B_BUS];
		end
		if (ram_start) begin
			nxt_ctrl[`RBLS_B_RGO] = 1'b1;
			nxt_ctrl[`RBLS_B_RPASS] = 1'b0;
			nxt_ctrl[`RBLS_B_RFAIL] = 1'b0;
		end
		if (st_ff == rbls_pkg::RBLS_RUN && ram_rep.step) begin
			if (any_err) begin
				nxt_ctrl[`RBLS_B_RFAIL] = 1'b1;
			end
		end
		if (st_ff == rbls_pkg::RBLS_DONE) begin
			nxt_ctrl[`RBLS_B_RGO] = 1'b0;
			nxt_ctrl[`RBLS_B_RPASS] = !ctrl_ff[`RBLS_B_RFAIL];
		end
		if (loop_start) begin
			nxt_ctrl[`RBLS_B_LGO] = 1'b1;
			nxt_ctrl[`RBLS_B_LPASS] = 1'b0;
			nxt_ctrl[`RBLS_B_LFAIL] = 1'b0;
		end else if (ctrl_ff[`RBLS_B_LGO] && loop_done) begin
			nxt_ctrl[`RBLS_B_LGO] = 1'b0;
			nxt_ctrl[`RBLS_B_LPASS] = loop_ok;
			nxt_ctrl[`RBLS_B_LFAIL] = !loop_ok;
		end
		nxt_ctrl[7:6] = 2'b00;
	end

	// ---------------------------------------------
	// ram check sequencer and failure clue
	// ---------------------------------------------
	// one offset drives all four quadrants at once; the engine
	// reports each quadrant's compare, so a fault address is only
	// known to within the four aliases
	always_comb begin
		nxt_st = st_ff;
		nxt_ofs = ofs_ff;
		nxt_clue = clue_ff;
		unique case (st_ff)
			rbls_pkg::RBLS_IDLE: begin
				if (ram_start) begin
					nxt_st = rbls_pkg::RBLS_RUN;
					nxt_ofs = '0;
					nxt_clue = 16'h0000;
				end
			end
			rbls_pkg::RBLS_RUN: begin
				if (ram_rep.step) begin
					nxt_ofs = ofs_ff + OFS_W'(1);
					// latch only the first failing offset
					if (any_err && !ctrl_ff[`RBLS_B_RFAIL]) begin
						nxt_clue = 16'(ofs_ff);
					end
					if (ram_rep.last) begin
						nxt_st = rbls_pkg::RBLS_DONE;
					end
				end
			end
			rbls_pkg::RBLS_DONE: begin
				nxt_st = rbls_pkg::RBLS_IDLE;
			end
			default: begin
				nxt_st = rbls_pkg::RBLS_IDLE;
			end
		endcase
	end

	// ---------------------------------------------
	// read path
	// ---------------------------------------------
	// clue address is shared with the rt word in normal mode
	always_comb begin
		nxt_rdata = rdata_ff;
		if (reg_rd) begin
			if (reg_addr == ADDR_W'(`RBLS_ADDR_CTRL)) begin
				nxt_rdata = ctrl_ff;
			end else if (reg_addr == ADDR_W'(`RBLS_ADDR_CLUE)) begin
				nxt_rdata = test_s ? clue_ff : rt1_msg_info;
			end else begin
				nxt_rdata = 16'h0000;
			end
		end
	end

	// control register flops
	always_ff @(posedge clk) begin
		if (!nrst) begin
			ctrl_ff <= `RBLS_CTRL_RST;
		end else begin
			ctrl_ff <= nxt_ctrl;
		end
	end

	// sequencer flops; the clue survives until the next start
	always_ff @(posedge clk) begin
		if (!nrst) begin
			st_ff <= rbls_pkg::RBLS_IDLE;
			ofs_ff <= '0;
			clue_ff <= 16'h0000;
		end else begin
			st_ff <= nxt_st;
			ofs_ff <= nxt_ofs;
			clue_ff <= nxt_clue;
		end
	end

	// read data flop, held between reads
	always_ff @(posedge clk) begin
		if (!nrst) begin
			rdata_ff <= 16'h0000;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end

	// ---------------------------------------------
	// outputs to the engines
	// ---------------------------------------------
	assign reg_rdata = rdata_ff;
	assign ram_go = (st_ff == rbls_pkg::RBLS_RUN);
	// pattern choice goes straight to the checker engine
	assign ram_check_pattern_select = ctrl_ff[`RBLS_B_PSEL_HI:`RBLS_B_PSEL_LO];
	assign ram_offset = ofs_ff;
	// selects are live register bits; software should change them only while idle
	assign loop_cfg.analog = ctrl_ff[`RBLS_B_ANALOG];
	assign loop_cfg.cmd_sync = ctrl_ff[`RBLS_B_SYNC];
	assign loop_cfg.bus_b = ctrl_ff[`RBLS_B_BUS];
	assign loop_cfg.go = ctrl_ff[`RBLS_B_LGO];
	// digital loop keeps the transmitter quiet
	assign loop_tx_enable = ctrl_ff[`RBLS_B_LGO] && ctrl_ff[`RBLS_B_ANALOG];
endmodule

// ### test/rbls_properties.sv
// port assertions for the self-check control register block
`timescale 1ns/1ps
module rbls_properties (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// register port
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic [15:0] reg_rdata,
	// engine side
	input wire logic ram_go,
	input wire logic [12:0] ram_offset,
	input wire rbls_pkg::rbls_ram_rep_t ram_rep,
	input wire rbls_pkg::rbls_loop_cfg_t loop_cfg,
	input wire logic loop_tx_enable,
	input wire logic loop_done
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	// step reports before and at the final offset
	sequence mid_s; ram_go && ram_rep.step && !ram_rep.last; endsequence
	sequence end_s; ram_go && ram_rep.step && ram_rep.last; endsequence
	AST_TX: assert property (loop_tx_enable == (loop_cfg.go && loop_cfg.analog))
		else $error("tx enable");
	AST_ZERO: assert property (reg_rd && reg_addr == 8'h28 |=> reg_rdata[7:6] == 2'h0)
		else $error("unused bits");
	AST_CFG: assert property (reg_wr && reg_addr == 8'h28 |=>
		loop_cfg[3:1] == $past(reg_wdata[5:3])) else $error("loop selects");
	AST_OFS0: assert property ($rose(ram_go) |-> ram_offset == 13'h0)
		else $error("first offset");
	AST_STEP: assert property (mid_s |=> ram_offset == $past(ram_offset) + 13'h1)
		else $error("offset step");
	AST_RUN: assert property (mid_s |=> ram_go) else $error("early stop");
	AST_END: assert property (end_s |-> ##2 !ram_go) else $error("no stop");
	AST_LGO: assert property (loop_cfg.go && loop_done |=> !loop_cfg.go)
		else $error("loop go");
endmodule
bind rbls_top rbls_properties u_props (
	.clk(clk),
	.nrst(nrst),
	.reg_wr(reg_wr),
	.reg_rd(reg_rd),
	.reg_addr(reg_addr),
	.reg_wdata(reg_wdata),
	.reg_rdata(reg_rdata),
	.ram_go(ram_go),
	.ram_offset(ram_offset),
	.ram_rep(ram_rep),
	.loop_cfg(loop_cfg),
	.loop_tx_enable(loop_tx_enable),
	.loop_done(loop_done)
);

// ### test/rbls_far.sv
// behavioural ram checker and loopback engine beside the block
`timescale 1ns/1ps
module rbls_far (
	// clock
	input wire logic clk,
	// ram checker, quadrant two fails from bad_ofs upward
	input wire logic ram_go,
	input wire logic [12:0] ram_offset,
	input wire logic [12:0] bad_ofs,
	output rbls_pkg::rbls_ram_rep_t ram_rep,
	// loopback engine
	input wire rbls_pkg::rbls_loop_cfg_t loop_cfg,
	input wire logic lb_bad,
	output logic loop_done,
	output logic loop_ok
);
	logic fin;
	logic [1:0] cnt;
	initial {ram_rep, fin, cnt, loop_done, loop_ok} = 11'h0;
	// report every other cycle so the offset has moved before the next one
	always @(posedge clk) begin
		ram_rep <= 6'h0;
		if (!ram_go)
			fin <= 1'b0;
		else if (!ram_rep.step && !fin) begin
			ram_rep <= {1'b1, (ram_offset >= bad_ofs ? 4'h4 : 4'h0), ram_offset == 13'h7};
			fin <= ram_offset == 13'h7;
		end
	end
	// result after four cycles; the ok line wanders outside the done pulse
	always @(posedge clk) begin
		loop_done <= 1'b0;
		loop_ok <= ~loop_ok;
		if (cnt == 2'h3) begin
			loop_done <= 1'b1;
			loop_ok <= !lb_bad;
			cnt <= 2'h0;
		end else if (loop_cfg.go && !loop_done)
			cnt <= cnt + 2'h1;
	end
endmodule

// ### test/tb.sv
// self-checking bench for the self-check control register block
`timescale 1ns/1ps
module tb;
	logic clk, nrst, test_pin, reg_wr, reg_rd, ram_go, loop_tx_enable, loop_done, loop_ok, lb_bad;
	logic [7:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata, rdv;
	logic [15:0] rt1_msg_info = 16'h1234;
	logic [12:0] ram_offset, bad_ofs;
	logic [2:0] ram_check_pattern_select;
	rbls_pkg::rbls_ram_rep_t ram_rep;
	rbls_pkg::rbls_loop_cfg_t loop_cfg;
	int num_errors = 0;
	int samples_checked = 0;
	rbls_top dut (
		.clk(clk),
		.nrst(nrst),
		.test_pin(test_pin),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata),
		.rt1_msg_info(rt1_msg_info),
		.ram_go(ram_go),
		.ram_check_pattern_select(ram_check_pattern_select),
		.ram_offset(ram_offset),
		.ram_rep(ram_rep),
		.loop_cfg(loop_cfg),
		.loop_tx_enable(loop_tx_enable),
		.loop_done(loop_done),
		.loop_ok(loop_ok)
	);
	rbls_far far (
		.clk(clk),
		.ram_go(ram_go),
		.ram_offset(ram_offset),
		.bad_ofs(bad_ofs),
		.ram_rep(ram_rep),
		.loop_cfg(loop_cfg),
		.lb_bad(lb_bad),
		.loop_done(loop_done),
		.loop_ok(loop_ok)
	);
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		samples_checked++;
		if (g !== e) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task complete_run;
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// one-cycle strobes, launched and dropped on rising edges
	task wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		{reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
		@(posedge clk);
		reg_wr <= 1'b0;
		#1;
	endtask
	task rd(input logic [7:0] a);
		@(posedge clk);
		{reg_rd, reg_addr} <= {1'b1, a};
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 rdv = reg_rdata;
	endtask
	// bounded wait for the ram check or the loopback to finish
	task wait_idle(input logic lb);
		int n;
		for (n = 0; n < 200 && (lb ? loop_cfg.go : ram_go) !== 1'b0; n++) @(posedge clk);
		if (n == 200) begin
			chk("wait", 16'h0, 16'h1);
			complete_run();
		end
	endtask
	task run_pass;
		wr(8'h28, 16'h8000);
		wr(8'h28, 16'h9FC0);
		chk("ram_go", 16'h1, {15'h0, ram_go});
		chk("psel", 16'h3, {13'h0, ram_check_pattern_select});
		wait_idle(1'b0);
		rd(8'h28);
		chk("ctrl pass", 16'h9A00, rdv);
	endtask
	// failures at offsets 5..7: only the first is kept
	task run_fail;
		bad_ofs = 13'h0005;
		wr(8'h28, 16'h8400);
		wait_idle(1'b0);
		rd(8'h28);
		chk("ctrl fail", 16'h8100, rdv);
		rd(8'h1B);
		chk("clue", 16'h0005, rdv);
		@(posedge clk) test_pin <= 1'b0;
		repeat (3) @(posedge clk);
		rd(8'h1B);
		chk("rt word", 16'h1234, rdv);
		wr(8'h28, 16'h8400);
		rd(8'h28);
		chk("refused", 16'h8100, rdv);
	endtask
	// digital loop with command sync, then analog on bus b with a bad word
	task run_loop;
		logic [15:0] w;
		@(posedge clk) test_pin <= 1'b1;
		repeat (3) @(posedge clk);
		for (int i = 0; i < 2; i++) begin
			w = i ? 16'h802C : 16'h8014;
			lb_bad = i[0];
			wr(8'h28, w);
			chk("cfg", {11'h0, i[0], w[5:2]}, {11'h0, loop_tx_enable, loop_cfg});
			wait_idle(1'b1);
			rd(8'h28);
			chk("ctrl loop", {w[15:3], 3'h0} | 16'h0100 | (i ? 16'h1 : 16'h2), rdv);
		end
		// start refused while the enable bit is still low
		wr(8'h28, 16'h0000);
		wr(8'h28, 16'h0400);
		rd(8'h28);
		chk("no enable", 16'h0101, rdv);
	endtask
	initial begin
		{nrst, test_pin, reg_wr, reg_rd, lb_bad, reg_addr, reg_wdata} = 29'h0;
		bad_ofs = 13'h1FFF;
		repeat (20) @(posedge clk);
		{nrst, test_pin} <= 2'h3;
		rd(8'h28);
		chk("ctrl reset", 16'h0000, rdv);
		run_pass();
		run_fail();
		run_loop();
		complete_run();
	end
endmodule
